// [bench/iclc_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// Enable and loop filter checks at the top ports
module iclc_checker (
   input wire logic                clk_sys,
   input wire logic                rst,
   input wire logic                stop_mode,
   input wire logic                internal_on_bit,
   input wire logic                external_on_bit,
   input wire iclc_pkg::iclc_cmp_t cmp_result,
   input wire logic                gen_stop_signal,
   input wire logic                internal_gen_enable,
   input wire logic                external_gen_enable,
   input wire logic                internal_clock,
   input wire logic                base_clock,
   input wire logic [3:0]          osc_divider_field,
   input wire logic [7:0]          osc_stage_field,
   input wire logic                filter_stable_flag
);
   logic tk;
   logic sm;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Strobe taken, and whether its band is inside the stable window
   assign tk = cmp_result.valid && internal_gen_enable;
   assign sm = cmp_result.band inside {iclc_pkg::ICLC_ERR_LOW_SMALL,
                                       iclc_pkg::ICLC_ERR_HI_SMALL};
   AST_STOP: assert property (gen_stop_signal == stop_mode)
      else $error("stop signal wrong");
   AST_IEN: assert property (internal_gen_enable == (internal_on_bit && !stop_mode))
      else $error("internal enable wrong");
   AST_EEN: assert property (external_gen_enable == (external_on_bit && !stop_mode))
      else $error("external enable wrong");
   AST_ILOW: assert property (!internal_gen_enable [*2] |-> !internal_clock && !base_clock)
      else $error("clock not low while off");
   AST_DN: assert property (tk && cmp_result.band == iclc_pkg::ICLC_ERR_LOW_BIG |=>
      osc_stage_field == $past(osc_stage_field) - 8'h20) else $error("big step wrong");
   AST_BORROW: assert property (tk && cmp_result.band == iclc_pkg::ICLC_ERR_LOW_SMALL &&
      osc_stage_field == 8'h00 && osc_divider_field inside {[4'h1:4'h8]} |=>
      osc_divider_field == $past(osc_divider_field) - 4'h1) else $error("borrow wrong");
   AST_HOLD: assert property (!tk |=> $stable(osc_stage_field) && $stable(osc_divider_field))
      else $error("word moved without strobe");
   AST_FLAG: assert property (tk |=> filter_stable_flag == $past(sm))
      else $error("stable flag wrong");
endmodule
bind iclc_top iclc_checker u_chk (.*);
`default_nettype wire

// [bench/iclc_sys_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Bus clock consumer; sampling on the system clock limits it to slow clocks
module iclc_sys_model (
   input  wire logic clk_sys,
   input  wire logic clr,
   input  wire logic bus_clock,
   input  wire logic generator_output_clock,
   input  wire logic osc_output_clock,
   output var int    n_bus,
   output var int    n_gen,
   output var int    n_osc
);
   logic [2:0] prv = 3'h0;
   // Rising edge counts of the derived clocks
   always @(posedge clk_sys) begin
      prv <= {bus_clock, generator_output_clock, osc_output_clock};
      n_bus <= clr ? 0 : n_bus + int'(bus_clock & ~prv[2]);
      n_gen <= clr ? 0 : n_gen + int'(generator_output_clock & ~prv[1]);
      n_osc <= clr ? 0 : n_osc + int'(osc_output_clock & ~prv[0]);
   end
endmodule
`default_nettype wire

// [bench/iclc_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic                clk_sys = 1'b0;
   logic                rst = 1'b1;
   logic                stop_mode = 1'b0;
   logic                internal_on_bit = 1'b0;
   logic                external_on_bit = 1'b0;
   logic                osc_tick = 1'b0;
   logic                ext_clk_in = 1'b0;
   logic                use_external = 1'b0;
   logic                clr = 1'b1;
   logic [7:0]          multiplier_register = 8'h00;
   iclc_pkg::iclc_cmp_t cmp_result = '0;
   logic                gen_stop_signal, internal_gen_enable, external_gen_enable, base_tick;
   logic                internal_clock, external_clock, base_clock, filter_stable_flag;
   logic                osc_output_clock, generator_output_clock, bus_clock, pi, pb, fexp;
   logic [3:0]          osc_divider_field;
   logic [7:0]          osc_stage_field;
   logic [11:0]         word = 12'h000;
   logic [7:0]          mults [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05};
   int                  failures = 0, total_checks = 0, ci = 0, cb = 0, n_bus, n_gen, n_osc;

   iclc_top DUT (.*);
   iclc_sys_model u_sys (.*);

   always #20 clk_sys = ~clk_sys;

   // Random ticks and pin just after the edge; edge counts of internal and base clocks
   always @(posedge clk_sys) begin
      #1;
      if (internal_clock === 1'b1 && pi === 1'b0) ci++;
      if (base_clock === 1'b1 && pb === 1'b0) cb++;
      pi = internal_clock;
      pb = base_clock;
      osc_tick = ($urandom_range(0, 2) == 0);
      ext_clk_in = 1'($urandom_range(0, 1));
   end

   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Step per band, word wraps modulo 4096
   function automatic logic [11:0] nxt(logic [11:0] w, logic [2:0] b);
      case (b)
         3'h0: return w - 12'h020;
         3'h1: return w - 12'h008;
         3'h2: return w - 12'h001;
         3'h3: return w + 12'h001;
         3'h4: return w + 12'h008;
         default: return w + 12'h020;
      endcase
   endfunction

   // Out of range divider reads as the slowest setting
   function automatic logic [11:0] shown(logic [11:0] w);
      return {(w[11:8] > 4'h9) ? 4'h9 : w[11:8], w[7:0]};
   endfunction

   function automatic logic [11:0] en3(int i);
      return {9'h000, i[2], i[1] & ~i[2], i[0] & ~i[2]};
   endfunction

   function automatic logic near(int a, int b, int t);
      return (a - b <= t) && (b - a <= t);
   endfunction

   task automatic strobe(input logic [2:0] b);
      cmp_result.valid = 1'b1;
      cmp_result.band = iclc_pkg::iclc_err_band_t'(b);
      fexp = 1'b0;
      if (internal_on_bit && !stop_mode) begin
         word = nxt(word, b);
         fexp = (b == 3'h2 || b == 3'h3);
      end
      @(posedge clk_sys);
      #1;
      chk({osc_divider_field, osc_stage_field}, shown(word));
      chk({11'h000, filter_stable_flag}, {11'h000, fexp});
   endtask

   task automatic window(input logic [7:0] n, input logic ue);
      int m;
      m = (n < 2) ? 1 : n;
      multiplier_register = n;
      use_external = ue;
      clr = 1'b1;
      repeat (20) @(posedge clk_sys);
      #1 clr = 1'b0;
      ci = 0;
      cb = 0;
      repeat (600) @(posedge clk_sys);
      #1;
      chk({11'h000, near(ci, m * cb, m + 1)}, 12'h001);
      chk({11'h000, near(2 * n_bus, n_gen, 2)}, 12'h001);
      chk({11'h000, near(4 * n_bus, n_osc, 4)}, 12'h001);
      $display("test divide %0d source %0d done", n, ue);
   endtask

   task automatic summarize();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin
      void'($urandom(74819));
      repeat (16) @(posedge clk_sys);
      #1 rst = 1'b0;
      @(posedge clk_sys);
      #1;
      chk({osc_divider_field, osc_stage_field}, 12'h000);
      chk({11'h000, filter_stable_flag}, 12'h000);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         {stop_mode, internal_on_bit, external_on_bit} = 3'(i);
         repeat (3) @(posedge clk_sys);
         #1;
         chk({9'h000, gen_stop_signal, internal_gen_enable, external_gen_enable}, en3(i));
         if (internal_gen_enable !== 1'b1) chk({10'h000, internal_clock, base_clock}, 12'h000);
         if (external_gen_enable !== 1'b1) chk({11'h000, external_clock}, 12'h000);
      end
      $display("test enables done");
      stop_mode = 1'b0;
      // Borrow below zero, sink through the slow range, then wander at random
      strobe(3'h2);
      repeat (52) strobe(3'h0);
      repeat (200) begin
         strobe(3'($urandom_range(0, 5)));
         if ($urandom_range(0, 3) == 0) begin
            cmp_result.valid = 1'b0;
            @(posedge clk_sys);
            #1;
         end
      end
      internal_on_bit = 1'b0;
      repeat (2) strobe(3'h5);
      cmp_result.valid = 1'b0;
      internal_on_bit = 1'b1;
      $display("test filter done");
      foreach (mults[k]) window(mults[k], 1'(k % 2));
      summarize();
   end

   // Whole run needs about 3500 cycles; this stops a hang well beyond that
   initial begin
      #1000000;
      failures++;
      summarize();
   end
endmodule
`default_nettype wire

// [hw/iclc_defs.svh]
`ifndef ICLC_DEFS_SVH
`define ICLC_DEFS_SVH

// Control word layout: divider field above stage field
`define ICLC_WORD_W      12
`define ICLC_DIV_MSB     11
`define ICLC_DIV_LSB     8
`define ICLC_STG_MSB     7
`define ICLC_STG_LSB     0
`define ICLC_WORD_RST    12'h000
`define ICLC_WORD_MAX    12'h9FF
`define ICLC_DIV_SLOW    4'h9
`define ICLC_DIV_OVR_MIN 4'hA
// Correction steps
`define ICLC_STEP_BIG    12'h020
`define ICLC_STEP_MID    12'h008
`define ICLC_STEP_ONE    12'h001
// Multiplier
`define ICLC_MULT_W      8
`define ICLC_MULT_BYPASS 8'h01
// Output clock dividers: generator out = bus x2, osc out = bus x4
`define ICLC_BUS_DIV_W   2

`endif

// [hw/iclc_divider.sv]
`timescale 1ns/1ps
`default_nettype none
`include "iclc_defs.svh"

// Modulo N clock divider producing a level clock and a one-cycle wrap tick
module iclc_divider #(
   parameter int W = 8
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         run,
   input  wire logic         tick_in,
   input  wire logic [W-1:0] modulus,
   output logic              clk_out,
   output logic              tick_out
);

   logic [W-1:0] cnt_r;
   logic         half;

   // Output high for the first half of the period
   assign half = (cnt_r < (modulus >> 1));

   // Count input ticks, wrap at modulus; held clear while stopped
   always_ff @(posedge clk_sys) begin
      if (rst || !run) begin
         cnt_r <= '0;
      end else if (tick_in) begin
         if (cnt_r >= modulus - W'(1)) begin
            cnt_r <= '0;
         end else begin
            cnt_r <= cnt_r + W'(1);
         end
      end
   end

   // Registered clock level; low while stopped
   always_ff @(posedge clk_sys) begin
      if (rst || !run) begin
         clk_out <= 1'b0;
      end else begin
         clk_out <= half;
      end
   end

   assign tick_out = run && tick_in && (cnt_r >= modulus - W'(1));

endmodule

`default_nettype wire

// [hw/iclc_pkg.sv]
package iclc_pkg;

   // Frequency error band reported by the comparator
   typedef enum logic [2:0] {
      ICLC_ERR_LOW_BIG,   // below 0.85 nominal
      ICLC_ERR_LOW_MID,   // 0.85 to 0.95
      ICLC_ERR_LOW_SMALL, // 0.95 to nominal
      ICLC_ERR_HI_SMALL,  // nominal to 1.05
      ICLC_ERR_HI_MID,    // 1.05 to 1.15
      ICLC_ERR_HI_BIG     // above 1.15
   } iclc_err_band_t;

   // Comparator result carried with its strobe
   typedef struct packed {
      logic           valid;
      iclc_err_band_t band;
   } iclc_cmp_t;

   // Oscillator control word
   typedef struct packed {
      logic [3:0] div_field;
      logic [7:0] stg_field;
   } iclc_word_t;

endpackage

// [hw/iclc_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "iclc_defs.svh"

// What this block does
// - Bus clock is quarter of osc output clock and half of generator output.
// - Stop mode asserts stop signal, holding internal, external and base clocks low.
// - Internal enable equals internal-on bit and not stop; generator runs only then.
// - Internal enable low turns generator off; internal and base clocks low.
// - External enable equals external-on bit and not stop; else external clock low.
// - Base clock is internal clock divided by programmed multiplier.
// - Multiplier of one or zero bypasses divider; internal clock passes straight.
// - Control word is 4-bit divider field above 8-bit stage field, 000 to 9FF.
// - Filter adds correction to the 12-bit word per comparator error band.
// - Slow bands correct by minus 32, minus 8, minus 1.
// - Fast bands correct by plus 1, plus 8, plus 32.
// - Divider field A to F is treated as 9, slowest setting.
// - Out-of-range word recovers by ordinary subtraction; settling above 9FF allowed.
// - Stable flag set while error lies within plus or minus 5 percent.
// - Settled loop gives base clock at 307.2 kHz nominal.
// - Divider field changes only by carry or borrow out of stage field.
module iclc_top (
   input  wire logic               clk_sys,
   input  wire logic               rst,
   input  wire logic               stop_mode,
   input  wire logic               internal_on_bit,
   input  wire logic               external_on_bit,
   input  wire logic [7:0]         multiplier_register,
   input  wire logic               osc_tick,
   input  wire logic               ext_clk_in,
   input  wire iclc_pkg::iclc_cmp_t cmp_result,
   input  wire logic               use_external,
   output logic                    gen_stop_signal,
   output logic                    internal_gen_enable,
   output logic                    external_gen_enable,
   output logic                    internal_clock,
   output logic                    external_clock,
   output logic                    base_clock,
   output logic                    base_tick,
   output logic [3:0]              osc_divider_field,
   output logic [7:0]              osc_stage_field,
   output logic                    filter_stable_flag,
   output logic                    osc_output_clock,
   output logic                    generator_output_clock,
   output logic                    bus_clock
);

   iclc_pkg::iclc_word_t word_r;
   logic [`ICLC_WORD_W-1:0] word_nxt;
   logic [`ICLC_WORD_W-1:0] step;
   logic                    step_up;
   logic                    bypass;
   logic                    div_clk;
   logic                    div_tick;
   logic                    int_lvl_r;
   logic                    ext_lvl_r;
   logic                    src_clk;
   logic                    int_rise;
   logic [`ICLC_BUS_DIV_W-1:0] bus_cnt_r;

   // Stop and enable gating
   assign gen_stop_signal     = stop_mode;
   assign internal_gen_enable = internal_on_bit && !gen_stop_signal;
   assign external_gen_enable = external_on_bit && !gen_stop_signal;

   // Internal clock level follows oscillator ticks, low when disabled
   always_ff @(posedge clk_sys) begin
      if (rst || !internal_gen_enable) begin
         int_lvl_r <= 1'b0;
      end else if (osc_tick) begin
         int_lvl_r <= !int_lvl_r;
      end
   end

   // External path buffered, held low when disabled
   always_ff @(posedge clk_sys) begin
      if (rst || !external_gen_enable) begin
         external_clock <= 1'b0;
      end else begin
         external_clock <= ext_clk_in;
      end
   end

   assign internal_clock = int_lvl_r;

   // Rising edge of the internal clock: one full internal period per pulse,
   // so the divider counts periods rather than half periods
   assign int_rise = internal_gen_enable && osc_tick && !int_lvl_r;

   // Modulo N divider; bypass for N of zero or one
   assign bypass = (multiplier_register <= `ICLC_MULT_BYPASS);

   iclc_divider #(
      .W (`ICLC_MULT_W)
   ) u_base_div (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .run      (internal_gen_enable),
      .tick_in  (int_rise),
      .modulus  (multiplier_register),
      .clk_out  (div_clk),
      .tick_out (div_tick)
   );

   // Base clock low while internal generator disabled
   assign base_clock = internal_gen_enable && (bypass ? int_lvl_r : div_clk);
   assign base_tick  = internal_gen_enable && (bypass ? int_rise : div_tick);

   // Correction step from error band
   always_comb begin
      step    = `ICLC_STEP_ONE;
      step_up = 1'b0;
      case (cmp_result.band)
         iclc_pkg::ICLC_ERR_LOW_BIG: begin
            step = `ICLC_STEP_BIG;
         end
         iclc_pkg::ICLC_ERR_LOW_MID: begin
            step = `ICLC_STEP_MID;
         end
         iclc_pkg::ICLC_ERR_LOW_SMALL: begin
            step = `ICLC_STEP_ONE;
         end
         iclc_pkg::ICLC_ERR_HI_SMALL: begin
            step    = `ICLC_STEP_ONE;
            step_up = 1'b1;
         end
         iclc_pkg::ICLC_ERR_HI_MID: begin
            step    = `ICLC_STEP_MID;
            step_up = 1'b1;
         end
         iclc_pkg::ICLC_ERR_HI_BIG: begin
            step    = `ICLC_STEP_BIG;
            step_up = 1'b1;
         end
         default: begin
            step    = '0;
            step_up = 1'b0;
         end
      endcase
   end

   // Plain 12-bit add: divider field moves only via stage carry or borrow,
   // and wraps freely so out-of-range words recover by subtraction
   assign word_nxt = step_up ? (word_r + step) : (word_r - step);

   // One update per comparison strobe, only while generator runs
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         word_r <= `ICLC_WORD_RST;
      end else if (internal_gen_enable && cmp_result.valid) begin
         word_r <= word_nxt;
      end
   end

   // Stable flag: within the two bands around nominal
   always_ff @(posedge clk_sys) begin
      if (rst || !internal_gen_enable) begin
         filter_stable_flag <= 1'b0;
      end else if (cmp_result.valid) begin
         filter_stable_flag <= (cmp_result.band == iclc_pkg::ICLC_ERR_LOW_SMALL) ||
                               (cmp_result.band == iclc_pkg::ICLC_ERR_HI_SMALL);
      end
   end

   // Oscillator sees A..F as the slowest setting 9
   assign osc_divider_field = (word_r.div_field >= `ICLC_DIV_OVR_MIN) ?
                              `ICLC_DIV_SLOW : word_r.div_field;
   assign osc_stage_field   = word_r.stg_field;

   // Selected source clock for the output dividers
   assign src_clk = use_external ? external_clock : int_lvl_r;

   // Toggle chain: bus = gen/2 = osc/4; counter steps on source edges
   always_ff @(posedge clk_sys) begin
      if (rst || gen_stop_signal) begin
         bus_cnt_r <= '0;
      end else if (src_clk && !(use_external ? ext_lvl_r : 1'b0) && use_external) begin
         bus_cnt_r <= bus_cnt_r + `ICLC_BUS_DIV_W'(1);
      end else if (!use_external && osc_tick && internal_gen_enable) begin
         bus_cnt_r <= bus_cnt_r + `ICLC_BUS_DIV_W'(1);
      end
   end

   // Previous external level for edge detection
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ext_lvl_r <= 1'b0;
      end else begin
         ext_lvl_r <= external_clock;
      end
   end

   // Osc output toggles per internal clock edge or external rising edge, generator output is half, bus quarter
   assign osc_output_clock       = bus_cnt_r[0];
   assign generator_output_clock = bus_cnt_r[1];

   // Bus clock halves the generator output; 
   logic bus_lvl_r;
   logic gen_prev_r;
   always_ff @(posedge clk_sys) begin
      if (rst || gen_stop_signal) begin
         bus_lvl_r  <= 1'b0;
         gen_prev_r <= 1'b0;
      end else begin
         gen_prev_r <= bus_cnt_r[1];
         if (bus_cnt_r[1] && !gen_prev_r) begin
            bus_lvl_r <= !bus_lvl_r;
         end
      end
   end
   assign bus_clock = bus_lvl_r;

endmodule

`default_nettype wire
